//--- iuv_pkg.sv
// package for the i/o and user-variable command handler
// assumes a byte-serial frame link and an external non-volatile store
package iuv_pkg;
    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_INSTR = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_BANK = 4'h3;
    localparam logic [3:0] IDX_VAL3 = 4'h4;
    localparam logic [3:0] IDX_CSUM = 4'h8;
    localparam logic [3:0] LAST_REPLY = 4'h8;
    // ------------------------------------------------------------------
    // instruction codes, banks, status
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_STORE = 8'h0b;
    localparam logic [7:0] CMD_RESTORE = 8'h0c;
    localparam logic [7:0] CMD_SET_OUT = 8'h0e;
    localparam logic [7:0] CMD_READ = 8'h0f;
    localparam logic [7:0] BANK_DIG_IN = 8'h00;
    localparam logic [7:0] BANK_ANALOG = 8'h01;
    localparam logic [7:0] BANK_USER = 8'h02;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] DEF_HOST_ADDR = 8'h02;
    localparam logic [7:0] DEF_MOD_ADDR = 8'h01;
    localparam int NUM_DIG_IN = 5;
    localparam int NUM_OUT = 4;
    localparam int NUM_ADC = 3;
    localparam int ADC_W = 12;
    localparam int NUM_VARS = 256;

    typedef enum {
        IUV_IDLE, IUV_RX, IUV_EXEC, IUV_NV_WAIT, IUV_TX, IUV_BOOT
    } iuv_state_e;
endpackage // iuv_pkg

//--- iuv_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to sys_clk
module iuv_sync #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } iuv_sync_s;
    iuv_sync_s st_ff, nxt_st;

    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;
endmodule // iuv_sync

//--- iuv_cmd_handler.sv
// command handler for user-variable store/restore and i/o port commands
// assumes byte frames from a host link and a handshaked nv store port
module iuv_cmd_handler #(
    parameter logic [7:0] HOST_ADDR = iuv_pkg::DEF_HOST_ADDR,
    parameter logic [7:0] MOD_ADDR = iuv_pkg::DEF_MOD_ADDR
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic standalone,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    output logic nv_req,
    output logic nv_write,
    output logic [7:0] nv_index,
    input wire logic nv_done,
    output logic [7:0] restore_index,
    output logic restore_valid,
    input wire logic [1:0] gp_in,
    input wire logic ref_right,
    input wire logic ref_left,
    input wire logic ref_home,
    input wire logic [2:0] analog_dig,
    input wire logic [11:0] analog_in_zero,
    input wire logic [11:0] analog_in_one,
    input wire logic [11:0] analog_in_two,
    output logic [3:0] gp_out,
    output logic [31:0] accum
);
    // ------------------------------------------------------------------
    // state and synchronised pins
    // ------------------------------------------------------------------
    typedef struct packed {
        iuv_pkg::iuv_state_e st;
        logic [3:0] cnt;
        logic [7:0] sum;
        logic [7:0] instr;
        logic [7:0] ptype;
        logic [7:0] bank;
        logic [31:0] value;
        logic [7:0] status;
        logic [31:0] rvalue;
        logic [3:0] out;
        logic [31:0] acc;
        logic nv_req;
        logic nv_write;
        logic [7:0] nv_index;
        logic [7:0] boot_idx;
        logic boot_last;
        logic rest_valid;
        logic tx_valid;
        logic [7:0] tx_byte;
    } iuv_s;
    iuv_s st_ff, nxt_st;

    logic [4:0] din_sync;
    logic [2:0] adig_sync;

    iuv_sync #(.W(5)) u_sync_din (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d({ref_home, ref_left, ref_right, gp_in}),
        .q(din_sync)
    );
    iuv_sync #(.W(3)) u_sync_adig (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d(analog_dig),
        .q(adig_sync)
    );
    // analog words are taken as already sampled by the converter on sys_clk

    // ------------------------------------------------------------------
    // reply byte selection
    // ------------------------------------------------------------------
    function automatic logic [7:0] reply_byte(input logic [3:0] i,
            input logic [7:0] stat, input logic [7:0] ins,
            input logic [31:0] v, input logic [7:0] sum);
        logic [7:0] b;
        b = sum;
        case (i)
            4'h0: b = HOST_ADDR;
            4'h1: b = MOD_ADDR;
            4'h2: b = stat;
            4'h3: b = ins;
            4'h4: b = v[31:24];
            4'h5: b = v[23:16];
            4'h6: b = v[15:8];
            4'h7: b = v[7:0];
            default: b = sum;
        endcase
        return b;
    endfunction

    logic [7:0] rd_port;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_port = st_ff.ptype;
        rd_val = '0;
        rd_ok = 1'b0;
        case (st_ff.bank)
            iuv_pkg::BANK_DIG_IN: begin
                if (rd_port < 8'(iuv_pkg::NUM_DIG_IN)) begin
                    rd_ok = 1'b1;
                    rd_val = {31'h0, din_sync[rd_port[2:0]]};
                end else if (rd_port < 8'(iuv_pkg::NUM_DIG_IN
                        + iuv_pkg::NUM_ADC)) begin
                    // analog pins as levels, no mode switch needed
                    rd_ok = 1'b1;
                    rd_val = {31'h0, adig_sync[rd_port[1:0] - 2'h1]};
                end
            end
            iuv_pkg::BANK_ANALOG: begin
                rd_ok = rd_port < 8'(iuv_pkg::NUM_ADC);
                case (rd_port[1:0])
                    2'h0: rd_val = {20'h0, analog_in_zero};
                    2'h1: rd_val = {20'h0, analog_in_one};
                    default: rd_val = {20'h0, analog_in_two};
                endcase
            end
            iuv_pkg::BANK_USER: begin
                rd_ok = rd_port < 8'(iuv_pkg::NUM_OUT);
                rd_val = {31'h0, st_ff.out[rd_port[1:0]]};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rest_valid = 1'b0;
        case (st_ff.st)
            iuv_pkg::IUV_BOOT: begin
                // reload every variable before taking commands
                if (!st_ff.nv_req) begin
                    nxt_st.nv_req = 1'b1;
                    nxt_st.nv_write = 1'b0;
                    nxt_st.nv_index = st_ff.boot_idx;
                end else if (nv_done) begin
                    nxt_st.nv_req = 1'b0;
                    nxt_st.rest_valid = 1'b1;
                    nxt_st.boot_idx = st_ff.boot_idx + 8'h01;
                    if (st_ff.boot_idx == 8'(iuv_pkg::NUM_VARS - 1)) begin
                        nxt_st.st = iuv_pkg::IUV_IDLE;
                    end
                end
            end
            iuv_pkg::IUV_IDLE: begin
                nxt_st.cnt = '0;
                nxt_st.sum = '0;
                if (rx_valid) begin
                    nxt_st.sum = rx_byte;
                    nxt_st.cnt = 4'h1;
                    nxt_st.st = iuv_pkg::IUV_RX;
                end
            end
            iuv_pkg::IUV_RX: begin
                if (rx_valid) begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                    nxt_st.sum = st_ff.sum + rx_byte;
                    case (st_ff.cnt)
                        iuv_pkg::IDX_INSTR: nxt_st.instr = rx_byte;
                        iuv_pkg::IDX_TYPE: nxt_st.ptype = rx_byte;
                        iuv_pkg::IDX_BANK: nxt_st.bank = rx_byte;
                        iuv_pkg::IDX_CSUM: nxt_st.st = iuv_pkg::IUV_EXEC;
                        default: nxt_st.value = {st_ff.value[23:0], rx_byte};
                    endcase
                    if (st_ff.cnt == iuv_pkg::IDX_CSUM) begin
                        nxt_st.status = (st_ff.sum == rx_byte)
                            ? iuv_pkg::STATUS_OK
                            : iuv_pkg::STATUS_BAD_CSUM;
                    end
                end
            end
            iuv_pkg::IUV_EXEC: begin
                nxt_st.rvalue = '0;
                nxt_st.st = iuv_pkg::IUV_TX;
                if (st_ff.status == iuv_pkg::STATUS_OK) begin
                    case (st_ff.instr)
                        iuv_pkg::CMD_STORE, iuv_pkg::CMD_RESTORE: begin
                            if (st_ff.bank == iuv_pkg::BANK_USER) begin
                                nxt_st.nv_req = 1'b1;
                                nxt_st.nv_write = st_ff.instr
                                    == iuv_pkg::CMD_STORE;
                                nxt_st.nv_index = st_ff.ptype;
                                nxt_st.st = iuv_pkg::IUV_NV_WAIT;
                            end else begin
                                nxt_st.status = iuv_pkg::STATUS_BAD_VALUE;
                            end
                        end
                        iuv_pkg::CMD_SET_OUT: begin
                            if (st_ff.bank != iuv_pkg::BANK_USER
                                    || st_ff.ptype
                                    >= 8'(iuv_pkg::NUM_OUT)) begin
                                nxt_st.status = iuv_pkg::STATUS_BAD_TYPE;
                            end else if (st_ff.value > 32'h1) begin
                                nxt_st.status = iuv_pkg::STATUS_BAD_VALUE;
                            end else begin
                                nxt_st.out[st_ff.ptype[1:0]] =
                                    st_ff.value[0];
                            end
                        end
                        iuv_pkg::CMD_READ: begin
                            if (rd_ok) begin
                                nxt_st.rvalue = rd_val;
                                if (standalone) begin
                                    nxt_st.acc = rd_val;
                                end
                                // direct mode: accumulator untouched
                            end else begin
                                nxt_st.status = iuv_pkg::STATUS_BAD_TYPE;
                            end
                        end
                        default: nxt_st.status = iuv_pkg::STATUS_BAD_CMD;
                    endcase
                end
                nxt_st.cnt = '0;
                nxt_st.sum = '0;
            end
            iuv_pkg::IUV_NV_WAIT: begin
                if (nv_done) begin
                    nxt_st.nv_req = 1'b0;
                    nxt_st.rest_valid = !st_ff.nv_write;
                    nxt_st.st = iuv_pkg::IUV_TX;
                end
            end
            iuv_pkg::IUV_TX: begin
                if (!st_ff.tx_valid || tx_ready) begin
                    if (st_ff.tx_valid && st_ff.cnt == iuv_pkg::LAST_REPLY) begin
                        nxt_st.tx_valid = 1'b0;
                        nxt_st.st = iuv_pkg::IUV_IDLE;
                    end else begin
                        nxt_st.tx_valid = 1'b1;
                        nxt_st.cnt = st_ff.tx_valid
                            ? st_ff.cnt + 4'h1 : 4'h0;
                        nxt_st.tx_byte = reply_byte(nxt_st.cnt,
                            st_ff.status, st_ff.instr, st_ff.rvalue,
                            nxt_st.sum);
                        nxt_st.sum = nxt_st.sum + nxt_st.tx_byte;
                    end
                end
            end
            default: nxt_st.st = iuv_pkg::IUV_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.st <= iuv_pkg::IUV_BOOT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tx_valid = st_ff.tx_valid;
    assign tx_byte = st_ff.tx_byte;
    assign nv_req = st_ff.nv_req;
    assign nv_write = st_ff.nv_write;
    assign nv_index = st_ff.nv_index;
    assign restore_index = st_ff.nv_index;
    assign restore_valid = st_ff.rest_valid;
    assign gp_out = st_ff.out;
    assign accum = st_ff.acc;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    bad_csum_status_a: assert property (
        st_ff.st == iuv_pkg::IUV_RX && rx_valid && st_ff.cnt
        == iuv_pkg::IDX_CSUM && rx_byte != st_ff.sum
        |=> st_ff.status == iuv_pkg::STATUS_BAD_CSUM)
        else $error("bad checksum not flagged");
    store_nv_write_a: assert property (
        st_ff.st == iuv_pkg::IUV_EXEC && st_ff.status == iuv_pkg::STATUS_OK
        && st_ff.instr == iuv_pkg::CMD_STORE && st_ff.bank
        == iuv_pkg::BANK_USER |=> nv_req && nv_write
        && nv_index == $past(st_ff.ptype))
        else $error("store did not write store");
    restore_nv_read_a: assert property (
        st_ff.st == iuv_pkg::IUV_EXEC && st_ff.status == iuv_pkg::STATUS_OK
        && st_ff.instr == iuv_pkg::CMD_RESTORE && st_ff.bank
        == iuv_pkg::BANK_USER |=> nv_req && !nv_write)
        else $error("restore did not read store");
    boot_reload_a: assert property (
        $fell(sys_rst) |-> ##[1:3] nv_req && !nv_write)
        else $error("no power-up reload");
    set_out_drive_a: assert property (
        st_ff.st == iuv_pkg::IUV_EXEC && st_ff.status == iuv_pkg::STATUS_OK
        && st_ff.instr == iuv_pkg::CMD_SET_OUT && st_ff.bank
        == iuv_pkg::BANK_USER && st_ff.ptype == 8'h0 && st_ff.value
        == 32'h1 |=> gp_out[0])
        else $error("output not driven");
    direct_acc_hold_a: assert property (
        !standalone && st_ff.st == iuv_pkg::IUV_EXEC |=> $stable(accum))
        else $error("direct read changed accumulator");
    alone_acc_load_a: assert property (
        standalone && st_ff.st == iuv_pkg::IUV_EXEC && st_ff.status
        == iuv_pkg::STATUS_OK && st_ff.instr == iuv_pkg::CMD_READ && rd_ok
        |=> accum == $past(rd_val))
        else $error("accumulator not loaded");
    reply_head_a: assert property (
        st_ff.st == iuv_pkg::IUV_EXEC && st_ff.status == iuv_pkg::STATUS_OK
        && st_ff.instr == iuv_pkg::CMD_READ && rd_ok
        ##1 !st_ff.tx_valid |=> tx_valid && tx_byte == HOST_ADDR)
        else $error("reply does not open with host address");
    read_range_a: assert property (
        st_ff.st == iuv_pkg::IUV_TX && st_ff.instr == iuv_pkg::CMD_READ
        |-> st_ff.rvalue[31:12] == 20'h0 && (st_ff.bank
        == iuv_pkg::BANK_ANALOG || st_ff.rvalue[11:1] == 11'h0))
        else $error("read value too wide");

    read_cov_c: cover property (st_ff.st == iuv_pkg::IUV_EXEC
        && st_ff.instr == iuv_pkg::CMD_READ);
    store_cov_c: cover property (nv_req && nv_write && nv_done);
    setout_cov_c: cover property ($rose(gp_out[3]));
    csum_cov_c: cover property (st_ff.status == iuv_pkg::STATUS_BAD_CSUM);
endmodule // iuv_cmd_handler

//--- iuv_nv_model.sv
// behavioural non-volatile store answering the handler's nv port
// assumes nv_req stands until nv_done, as the handler promises
module iuv_nv_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic nv_req,
    input wire logic nv_write,
    input wire logic [7:0] nv_index,
    output logic nv_done,
    output logic last_write,
    output logic [7:0] last_idx,
    output int n_ops
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    logic slow;
    // ------------------------------------------------------------------
    // answer alternately at once and after a stall
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nv_done <= 1'b0;
            cnt <= 3'h0;
            slow <= 1'b0;
            last_write <= 1'b0;
            last_idx <= 8'h00;
            n_ops <= 0;
        end else if (nv_done) begin
            nv_done <= 1'b0;
        end else if (nv_req) begin
            if (cnt == (slow ? 3'h4 : 3'h0)) begin
                nv_done <= 1'b1;
                cnt <= 3'h0;
                slow <= ~slow;
                last_write <= nv_write;
                last_idx <= nv_index;
                n_ops <= n_ops + 1;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule // iuv_nv_model

//--- tb_iuv_cmd_handler.sv
// self-checking bench for the command handler
// assumes the handler's own assertions watch the cycle-level timing
module tb_iuv_cmd_handler;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, sys_rst, rx_valid, standalone, tx_valid, tx_ready;
    logic nv_req, nv_write, nv_done, restore_valid, ref_right;
    logic ref_left, ref_home, last_write;
    logic [7:0] rx_byte, tx_byte, nv_index, restore_index, last_idx;
    logic [7:0] last_ridx;
    logic [1:0] gp_in;
    logic [2:0] analog_dig;
    logic [11:0] analog_in_zero, analog_in_one, analog_in_two;
    logic [3:0] gp_out;
    logic [31:0] accum;
    int n_ops, n_restore, fail_count, n_compared;

    iuv_cmd_handler DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .standalone(standalone),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .nv_req(nv_req), .nv_write(nv_write), .nv_index(nv_index),
        .nv_done(nv_done), .restore_index(restore_index),
        .restore_valid(restore_valid), .gp_in(gp_in),
        .ref_right(ref_right), .ref_left(ref_left), .ref_home(ref_home),
        .analog_dig(analog_dig), .analog_in_zero(analog_in_zero),
        .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
        .gp_out(gp_out), .accum(accum));
    iuv_nv_model nv (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .nv_req(nv_req), .nv_write(nv_write), .nv_index(nv_index),
        .nv_done(nv_done), .last_write(last_write), .last_idx(last_idx),
        .n_ops(n_ops));

    // ------------------------------------------------------------------
    // clock, restore tally, watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (restore_valid === 1'b1) begin
            n_restore++;
            last_ridx = restore_index;
        end
    end
    initial begin
        #(60000 * 100);
        fail_count++;
        $display("Error at %0t: watchdog ran out", $time);
        finish_test();
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #10;
    endtask
    // one frame in, whole reply out; bad adds to the checksum
    task automatic cmd(input logic [7:0] ins, input logic [7:0] ty,
        input logic [7:0] bk, input logic [31:0] v, input logic [7:0] bad,
        input logic [7:0] st, input logic [31:0] rv, input bit cv);
        logic [7:0] f[9];
        logic [7:0] b[9];
        logic [7:0] s;
        int k;
        f = '{8'h01, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], bad};
        for (int i = 0; i < 8; i++) f[8] += f[i];
        for (int i = 0; i < 9; i++) begin
            rx_valid = 1'b1;
            rx_byte = f[i];
            tick();
        end
        rx_valid = 1'b0;
        s = 8'h00;
        for (int i = 0; i < 9; i++) begin
            k = 0;
            while (tx_valid !== 1'b1 && k < 3000) begin
                tick();
                k++;
            end
            check(tx_valid, 1'b1);
            b[i] = tx_byte;
            tx_ready = 1'b1;
            tick();
            tx_ready = 1'b0;
            tick();
            if (i < 8) s += b[i];
        end
        check(b[0], iuv_pkg::DEF_HOST_ADDR);
        check(b[1], iuv_pkg::DEF_MOD_ADDR);
        check(b[2], st);
        check(b[3], ins);
        if (cv) check({b[4], b[5], b[6], b[7]}, rv);
        check(b[8], s);
        check(tx_valid, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_boot();
        int k;
        k = 0;
        while (n_restore < 256 && k < 20000) begin
            tick();
            k++;
        end
        repeat (4) tick();
        check(n_restore, 256);
        check(last_ridx, 8'hff);
    endtask
    task automatic t_user_var();
        int n;
        cmd(iuv_pkg::CMD_STORE, 8'h2a, iuv_pkg::BANK_USER, 0, 0,
            iuv_pkg::STATUS_OK, 0, 0);
        check({last_write, last_idx}, 9'h12a);
        n = n_restore;
        cmd(iuv_pkg::CMD_RESTORE, 8'h2a, iuv_pkg::BANK_USER, 32'h12345678,
            0, iuv_pkg::STATUS_OK, 0, 0);
        check({last_write, last_idx}, 9'h02a);
        check(n_restore, n + 1);
        check(last_ridx, 8'h2a);
        n = n_ops;
        cmd(iuv_pkg::CMD_STORE, 8'h05, iuv_pkg::BANK_DIG_IN, 0, 0,
            iuv_pkg::STATUS_BAD_VALUE, 0, 0);
        check(n_ops, n);
    endtask
    task automatic t_outputs();
        for (int p = 0; p < 4; p++) begin
            cmd(iuv_pkg::CMD_SET_OUT, p, iuv_pkg::BANK_USER, 1, 0,
                iuv_pkg::STATUS_OK, 0, 0);
            check(gp_out, (4'h1 << (p + 1)) - 4'h1);
            cmd(iuv_pkg::CMD_READ, p, iuv_pkg::BANK_USER, 0, 0,
                iuv_pkg::STATUS_OK, 1, 1);
        end
        cmd(iuv_pkg::CMD_SET_OUT, 1, iuv_pkg::BANK_USER, 0, 0,
            iuv_pkg::STATUS_OK, 0, 0);
        check(gp_out, 4'hd);
        cmd(iuv_pkg::CMD_READ, 1, iuv_pkg::BANK_USER, 0, 0,
            iuv_pkg::STATUS_OK, 0, 1);
        cmd(iuv_pkg::CMD_SET_OUT, 0, iuv_pkg::BANK_USER, 2, 0,
            iuv_pkg::STATUS_BAD_VALUE, 0, 0);
        check(gp_out, 4'hd);
    endtask
    task automatic t_inputs();
        logic [7:0] e;
        gp_in = 2'b01;
        ref_left = 1'b1;
        ref_home = 1'b1;
        analog_dig = 3'b101;
        e = 8'b10111001; // bit p expected at port p
        // second pass with every pin inverted catches stuck lines
        for (int n = 0; n < 2; n++) begin
            for (int p = 0; p < 8; p++) begin
                cmd(iuv_pkg::CMD_READ, p, iuv_pkg::BANK_DIG_IN,
                    32'hffffffff, 0, iuv_pkg::STATUS_OK, e[p],
                    1);
            end
            {gp_in, ref_right, ref_left, ref_home} =
                ~{gp_in, ref_right, ref_left, ref_home};
            analog_dig = ~analog_dig;
            e = ~e;
        end
    endtask
    task automatic t_analog();
        logic [11:0] a[3];
        a = '{12'hfff, 12'h12e, 12'h000};
        analog_in_zero = a[0];
        analog_in_one = a[1];
        analog_in_two = a[2];
        for (int p = 0; p < 3; p++) begin
            cmd(iuv_pkg::CMD_READ, p, iuv_pkg::BANK_ANALOG, 0, 0,
                iuv_pkg::STATUS_OK, a[p], 1);
        end
        check(accum, 0);
        standalone = 1'b1;
        cmd(iuv_pkg::CMD_READ, 1, iuv_pkg::BANK_ANALOG, 0, 0,
            iuv_pkg::STATUS_OK, 32'h12e, 1);
        check(accum, 32'h12e);
        standalone = 1'b0;
    endtask
    task automatic t_errors();
        // refused frames must leave the outputs alone
        cmd(iuv_pkg::CMD_SET_OUT, 0, iuv_pkg::BANK_USER, 0, 8'h01,
            iuv_pkg::STATUS_BAD_CSUM, 0, 0);
        check(gp_out, 4'hd);
        cmd(8'h2c, 0, iuv_pkg::BANK_USER, 0, 0,
            iuv_pkg::STATUS_BAD_CMD, 0, 0);
        cmd(iuv_pkg::CMD_SET_OUT, 4, iuv_pkg::BANK_USER, 0, 0,
            iuv_pkg::STATUS_BAD_TYPE, 0, 0);
        cmd(iuv_pkg::CMD_SET_OUT, 0, iuv_pkg::BANK_DIG_IN, 0, 0,
            iuv_pkg::STATUS_BAD_TYPE, 0, 0);
        check(gp_out, 4'hd);
        cmd(iuv_pkg::CMD_READ, 3, iuv_pkg::BANK_ANALOG, 0, 0,
            iuv_pkg::STATUS_BAD_TYPE, 0, 0);
        cmd(iuv_pkg::CMD_READ, 0, 8'h03, 0, 0,
            iuv_pkg::STATUS_BAD_TYPE, 0, 0);
        check(accum, 32'h12e);
    endtask
    task automatic t_reset();
        // a reset in mid-run clears the outputs and reboots the store
        sys_rst = 1'b1;
        repeat (2) tick();
        check(gp_out, 4'h0);
        check(accum, 0);
        n_restore = 0;
        sys_rst = 1'b0;
        t_boot();
    endtask

    initial begin
        {sys_rst, rx_valid, standalone, tx_ready, ref_right} = 5'h10;
        {ref_left, ref_home, rx_byte, gp_in, analog_dig} = 15'h0000;
        {analog_in_zero, analog_in_one, analog_in_two} = 36'h0;
        fail_count = 0;
        n_compared = 0;
        n_restore = 0;
        repeat (20) @(posedge sys_clk);
        #10;
        sys_rst = 1'b0;
        t_boot();
        t_user_var();
        t_outputs();
        t_inputs();
        t_analog();
        t_errors();
        t_reset();
        finish_test();
    end
endmodule // tb_iuv_cmd_handler
